// >>> erpi_top.sv
`timescale 1ns/100ps
// What this block does
// - RGMII transmit control: enable, then enable xor error
// - RGMII transmit nibbles: low rising, high falling
// - RGMII receive nibbles captured on both clock edges
// - RGMII receive control decoded: valid, valid xor error
// - RMII transmit dibit per reference cycle, lines 2-3 idle
// - RMII receive uses lines 0 and 1 only
// - RMII transmit control is a plain enable
// - RMII receive control yields carrier and data valid
// - Transmit clock pin driven as reference clock
// - Receive clock used in RGMII, ignored in RMII
module erpi_top (
	// System clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Mode selection
	input wire logic mode_rmii_in,
	output logic mode_rmii_out,
	// Transmit byte stream
	input wire logic tx_valid_in,
	input wire erpi_pkg::erpi_tx_byte_t tx_byte_in,
	output logic tx_ready_out,
	output logic tx_active_out,
	// Receive byte stream
	output logic rx_valid_out,
	output erpi_pkg::erpi_rx_word_t rx_word_out,
	input wire logic rx_ready_in,
	output logic rx_carrier_out,
	output logic rx_overflow_out,
	input wire logic rx_overflow_clear_in,
	// Transmit pins toward the PHY
	output logic mii_transmit_clock_out,
	output logic mii_transmit_control_out,
	output logic mii_transmit_bit0_out,
	output logic mii_transmit_bit1_out,
	output logic mii_transmit_bit2_out,
	output logic mii_transmit_bit3_out,
	// Receive pins from the PHY
	input wire logic mii_receive_clock_in,
	input wire logic mii_receive_control_in,
	input wire logic mii_receive_bit0_in,
	input wire logic mii_receive_bit1_in,
	input wire logic mii_receive_bit2_in,
	input wire logic mii_receive_bit3_in
);
	import erpi_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [RST_SYNC_W-1:0] rst_sync_reg;
	logic [RST_SYNC_W-1:0] rx_rst_sync_reg;
	logic rst_n;
	logic rx_rst_n;
	logic rx_clk_n;
	logic mode_reg;
	logic mode_upd;
	logic tx_busy;
	logic rx_busy;
	logic ref_clk_reg;
	erpi_tx_state_t tx_state_reg;
	erpi_tx_byte_t tx_hold_reg;
	logic [BYTE_W-1:0] tx_shift_reg;
	logic [1:0] tx_idx_reg;
	logic tx_ready_reg;
	logic tx_ready_next;
	logic tx_load_slot;
	logic tx_take;
	logic [NIB_W-1:0] tx_pins_reg;
	logic tx_ctl_reg;
	logic [NIB_W-1:0] rx_pins;
	logic [NIB_W-1:0] rg_rise_nib_reg;
	logic rg_rise_dv_reg;
	logic rg_prev_dv_reg;
	logic rg_mode_s1_reg;
	logic rg_mode_s2_reg;
	logic rg_drop_tgl_reg;
	erpi_rx_word_t rg_word;
	logic rg_wr_valid;
	logic rg_wr_ready;
	logic rg_dv_s1_reg;
	logic rg_dv_s2_reg;
	logic [2:0] drop_sync_reg;
	logic rg_drop_evt;
	logic fifo_rd_valid;
	logic fifo_rd_ready;
	erpi_rx_word_t fifo_rd_word;
	logic [RMII_PIN_W-1:0] rm_s1_reg;
	logic [RMII_PIN_W-1:0] rm_s2_reg;
	logic rm_sample;
	logic rm_crs_dv;
	logic [DIBIT_W-1:0] rm_dibit;
	erpi_rr_state_t rr_state_reg;
	logic [BYTE_W-1:0] rm_shift_reg;
	logic [1:0] rm_idx_reg;
	logic rm_first_reg;
	logic rm_dv_prev_reg;
	logic rm_carrier_reg;
	logic rm_byte_vld_reg;
	erpi_rx_word_t rm_word_reg;
	logic out_load;
	logic rm_drop;
	logic rx_valid_reg;
	erpi_rx_word_t rx_word_reg;
	logic carrier_reg;
	logic overflow_reg;

	// ----------------------------------------------------------------
	// Reset release, one copy per clock domain
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[RST_SYNC_W-1];

	// The receive clock may stand still, so this copy only releases once the PHY clocks.
	always_ff @(posedge mii_receive_clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_rst_sync_reg <= '0;
		end else begin
			rx_rst_sync_reg <= {rx_rst_sync_reg[0], 1'b1};
		end
	end
	assign rx_rst_n = rx_rst_sync_reg[RST_SYNC_W-1];
	assign rx_clk_n = ~mii_receive_clock_in;

	// ----------------------------------------------------------------
	// Mode latch
	// ----------------------------------------------------------------
	assign tx_busy = (tx_state_reg != TX_IDLE) || tx_ready_reg;
	assign rx_busy = (rr_state_reg != RR_IDLE) || rx_valid_reg || fifo_rd_valid || rg_dv_s2_reg;
	assign mode_upd = !tx_busy && !rx_busy && (mode_rmii_in != mode_reg);

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= 1'b0;
		end else if (mode_upd) begin
			mode_reg <= mode_rmii_in;
		end
	end
	assign mode_rmii_out = mode_reg;

	// ----------------------------------------------------------------
	// Reference clock, half the system clock in both modes
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ref_clk_reg <= 1'b0;
		end else begin
			ref_clk_reg <= ~ref_clk_reg;
		end
	end
	assign mii_transmit_clock_out = ref_clk_reg;

	// ----------------------------------------------------------------
	// Transmit sequencing
	// ----------------------------------------------------------------
	// A byte is taken where the clock rises in RGMII, or where the clock falls after
	// the last dibit in RMII; ready is raised only in the cycle before such an edge.
	assign tx_load_slot = mode_reg ?
		(ref_clk_reg && ((tx_state_reg == TX_IDLE) || (tx_idx_reg == DIBIT_LAST))) :
		!ref_clk_reg;
	assign tx_take = tx_load_slot && tx_ready_reg && tx_valid_in;
	assign tx_ready_next = !mode_upd && (mode_reg ?
		(!ref_clk_reg && ((tx_state_reg == TX_IDLE) || (tx_idx_reg == DIBIT_LAST))) :
		ref_clk_reg);

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready_reg <= 1'b0;
		end else begin
			tx_ready_reg <= tx_ready_next;
		end
	end
	assign tx_ready_out = tx_ready_reg;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= TX_IDLE;
			tx_hold_reg <= '0;
		end else if (tx_load_slot) begin
			tx_hold_reg <= tx_byte_in;
			case (tx_state_reg)
				TX_IDLE: begin
					tx_state_reg <= tx_take ? TX_SEND : TX_IDLE;
				end
				TX_SEND: begin
					tx_state_reg <= tx_take ? TX_SEND : TX_IDLE;
				end
				default: begin
					tx_state_reg <= TX_IDLE;
				end
			endcase
		end
	end
	assign tx_active_out = tx_ctl_reg;

	// ----------------------------------------------------------------
	// Transmit pins
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_pins_reg <= '0;
			tx_ctl_reg <= 1'b0;
			tx_shift_reg <= '0;
			tx_idx_reg <= DIBIT_FIRST;
		end else if (!mode_reg) begin
			if (!ref_clk_reg) begin
				tx_pins_reg <= tx_take ? tx_byte_in.data[NIB_W-1:0] : '0;
				tx_ctl_reg <= tx_take;
			end else if (tx_state_reg == TX_SEND) begin
				tx_pins_reg <= tx_hold_reg.data[BYTE_W-1:NIB_W];
				tx_ctl_reg <= ~tx_hold_reg.err;
			end else begin
				tx_pins_reg <= '0;
				tx_ctl_reg <= 1'b0;
			end
		end else if (ref_clk_reg) begin
			if (tx_load_slot) begin
				// Error is not encoded on the RMII control line.
				tx_ctl_reg <= tx_take;
				tx_pins_reg <= {{DIBIT_W{1'b0}}, tx_byte_in.data[DIBIT_W-1:0]};
				tx_shift_reg <= tx_byte_in.data >> DIBIT_W;
				tx_idx_reg <= DIBIT_FIRST;
			end else begin
				tx_pins_reg <= {{DIBIT_W{1'b0}}, tx_shift_reg[DIBIT_W-1:0]};
				tx_shift_reg <= tx_shift_reg >> DIBIT_W;
				tx_idx_reg <= tx_idx_reg + DIBIT_NEXT;
			end
		end
	end
	assign mii_transmit_control_out = tx_ctl_reg;
	assign mii_transmit_bit0_out = tx_pins_reg[0];
	assign mii_transmit_bit1_out = tx_pins_reg[1];
	assign mii_transmit_bit2_out = tx_pins_reg[2];
	assign mii_transmit_bit3_out = tx_pins_reg[3];

	// ----------------------------------------------------------------
	// RGMII receive, on the PHY clock
	// ----------------------------------------------------------------
	assign rx_pins = {mii_receive_bit3_in, mii_receive_bit2_in, mii_receive_bit1_in,
		mii_receive_bit0_in};

	always_ff @(posedge mii_receive_clock_in or negedge rx_rst_n) begin
		if (!rx_rst_n) begin
			rg_rise_nib_reg <= '0;
			rg_rise_dv_reg <= 1'b0;
			rg_prev_dv_reg <= 1'b0;
			rg_mode_s1_reg <= 1'b0;
			rg_mode_s2_reg <= 1'b0;
		end else begin
			rg_mode_s1_reg <= mode_reg;
			rg_mode_s2_reg <= rg_mode_s1_reg;
			rg_rise_nib_reg <= rx_pins;
			rg_rise_dv_reg <= mii_receive_control_in && !rg_mode_s2_reg;
			rg_prev_dv_reg <= rg_rise_dv_reg;
		end
	end

	// The byte is written at the falling edge that completes it, so no clock edge is
	// needed after the last byte of a frame.
	assign rg_word.first = rg_rise_dv_reg && !rg_prev_dv_reg;
	assign rg_word.err = rg_rise_dv_reg ^ mii_receive_control_in;
	assign rg_word.data = {rx_pins, rg_rise_nib_reg};
	assign rg_wr_valid = rg_rise_dv_reg;

	always_ff @(posedge rx_clk_n or negedge rx_rst_n) begin
		if (!rx_rst_n) begin
			rg_drop_tgl_reg <= 1'b0;
		end else if (rg_wr_valid && !rg_wr_ready) begin
			rg_drop_tgl_reg <= ~rg_drop_tgl_reg;
		end
	end

	erpi_fifo #(
		.WIDTH($bits(erpi_rx_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.wr_clk_in(rx_clk_n),
		.wr_rst_n_in(rx_rst_n),
		.wr_valid_in(rg_wr_valid),
		.wr_data_in(rg_word),
		.wr_ready_out(rg_wr_ready),
		.rd_clk_in(sys_clk_in),
		.rd_rst_n_in(rst_n),
		.rd_ready_in(fifo_rd_ready),
		.rd_valid_out(fifo_rd_valid),
		.rd_data_out(fifo_rd_word)
	);

	// ----------------------------------------------------------------
	// Crossings from the receive clock
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rg_dv_s1_reg <= 1'b0;
			rg_dv_s2_reg <= 1'b0;
			drop_sync_reg <= '0;
		end else begin
			rg_dv_s1_reg <= rg_rise_dv_reg;
			rg_dv_s2_reg <= rg_dv_s1_reg;
			drop_sync_reg <= {drop_sync_reg[1:0], rg_drop_tgl_reg};
		end
	end
	assign rg_drop_evt = drop_sync_reg[2] ^ drop_sync_reg[1];

	// ----------------------------------------------------------------
	// RMII receive, sampled where the reference clock rises
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rm_s1_reg <= '0;
			rm_s2_reg <= '0;
		end else begin
			rm_s1_reg <= {mii_receive_control_in, mii_receive_bit1_in, mii_receive_bit0_in};
			rm_s2_reg <= rm_s1_reg;
		end
	end
	assign rm_sample = mode_reg && !ref_clk_reg;
	assign rm_crs_dv = rm_s2_reg[RMII_CRS_DV_POS];
	assign rm_dibit = rm_s2_reg[DIBIT_W-1:0];

	// Alignment starts on the first preamble dibit; the frame ends only after two
	// low samples, since carrier may drop while buffered data still flows.
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rr_state_reg <= RR_IDLE;
			rm_shift_reg <= '0;
			rm_idx_reg <= DIBIT_FIRST;
			rm_first_reg <= 1'b0;
			rm_dv_prev_reg <= 1'b0;
			rm_carrier_reg <= 1'b0;
			rm_byte_vld_reg <= 1'b0;
			rm_word_reg <= '0;
		end else begin
			rm_byte_vld_reg <= 1'b0;
			if (!mode_reg) begin
				rr_state_reg <= RR_IDLE;
				rm_carrier_reg <= 1'b0;
			end else if (rm_sample) begin
				rm_dv_prev_reg <= rm_crs_dv;
				case (rr_state_reg)
					RR_IDLE, RR_HUNT: begin
						rm_carrier_reg <= rm_crs_dv;
						if (!rm_crs_dv) begin
							rr_state_reg <= RR_IDLE;
						end else if (rm_dibit == PREAMBLE_DIBIT) begin
							rr_state_reg <= RR_DATA;
							rm_shift_reg <= {rm_dibit, rm_shift_reg[BYTE_W-1:DIBIT_W]};
							rm_idx_reg <= DIBIT_NEXT;
							rm_first_reg <= 1'b1;
						end else begin
							rr_state_reg <= RR_HUNT;
						end
					end
					RR_DATA: begin
						if (!rm_idx_reg[0]) begin
							rm_carrier_reg <= rm_crs_dv;
						end
						if (!rm_crs_dv && !rm_dv_prev_reg) begin
							rr_state_reg <= RR_IDLE;
						end else begin
							rm_shift_reg <= {rm_dibit, rm_shift_reg[BYTE_W-1:DIBIT_W]};
							rm_idx_reg <= rm_idx_reg + DIBIT_NEXT;
							if (rm_idx_reg == DIBIT_LAST) begin
								rm_byte_vld_reg <= 1'b1;
								rm_word_reg.first <= rm_first_reg;
								rm_word_reg.err <= 1'b0;
								rm_word_reg.data <= {rm_dibit, rm_shift_reg[BYTE_W-1:DIBIT_W]};
								rm_first_reg <= 1'b0;
							end
						end
					end
					default: begin
						rr_state_reg <= RR_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive output stage
	// ----------------------------------------------------------------
	// RMII bytes have no buffer: a user that stalls longer than one byte time loses
	// data, which shows as overflow.
	assign out_load = !rx_valid_reg || rx_ready_in;
	assign fifo_rd_ready = !mode_reg && out_load;
	assign rm_drop = rm_byte_vld_reg && !out_load;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_valid_reg <= 1'b0;
			rx_word_reg <= '0;
		end else if (out_load) begin
			rx_valid_reg <= mode_reg ? rm_byte_vld_reg : fifo_rd_valid;
			rx_word_reg <= mode_reg ? rm_word_reg : fifo_rd_word;
		end
	end
	assign rx_valid_out = rx_valid_reg;
	assign rx_word_out = rx_word_reg;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			carrier_reg <= 1'b0;
		end else begin
			carrier_reg <= mode_reg ? rm_carrier_reg : rg_dv_s2_reg;
		end
	end
	assign rx_carrier_out = carrier_reg;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			overflow_reg <= 1'b0;
		end else if (rg_drop_evt || rm_drop) begin
			overflow_reg <= 1'b1;
		end else if (rx_overflow_clear_in) begin
			overflow_reg <= 1'b0;
		end
	end
	assign rx_overflow_out = overflow_reg;

endmodule

// >>> erpi_pkg.sv
package erpi_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int DIBIT_W = 2;
	localparam int RMII_PIN_W = 3;
	localparam int FIFO_DEPTH = 32;
	localparam int RST_SYNC_W = 2;

	// ----------------------------------------------------------------
	// Field positions of the RMII receive pin sample
	// ----------------------------------------------------------------
	localparam int RMII_CRS_DV_POS = 2;

	// ----------------------------------------------------------------
	// RMII dibit sequencing
	// ----------------------------------------------------------------
	localparam logic [1:0] DIBIT_FIRST = 2'h0;
	localparam logic [1:0] DIBIT_NEXT = 2'h1;
	localparam logic [1:0] DIBIT_LAST = 2'h3;
	localparam logic [1:0] PREAMBLE_DIBIT = 2'h1;

	// ----------------------------------------------------------------
	// Stream words
	// ----------------------------------------------------------------
	typedef struct packed {
		logic err;
		logic [BYTE_W-1:0] data;
	} erpi_tx_byte_t;

	typedef struct packed {
		logic first;
		logic err;
		logic [BYTE_W-1:0] data;
	} erpi_rx_word_t;

	// ----------------------------------------------------------------
	// State machines
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} erpi_tx_state_t;

	typedef enum logic [2:0] {
		RR_IDLE = 3'h1,
		RR_HUNT = 3'h2,
		RR_DATA = 3'h4
	} erpi_rr_state_t;

endpackage

// >>> erpi_fifo.sv
`timescale 1ns/100ps
module erpi_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	// Write side
	input wire logic wr_clk_in,
	input wire logic wr_rst_n_in,
	input wire logic wr_valid_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic wr_ready_out,
	// Read side
	input wire logic rd_clk_in,
	input wire logic rd_rst_n_in,
	input wire logic rd_ready_in,
	output logic rd_valid_out,
	output logic [WIDTH-1:0] rd_data_out
);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wbin_reg;
	logic [AW:0] wgray_reg;
	logic [AW:0] rbin_reg;
	logic [AW:0] rgray_reg;
	logic [AW:0] rgray_s1_reg;
	logic [AW:0] rgray_s2_reg;
	logic [AW:0] wgray_s1_reg;
	logic [AW:0] wgray_s2_reg;
	logic [AW:0] wbin_next;
	logic [AW:0] rbin_next;
	logic wr_fire;
	logic rd_fire;

	// Full compares against the read pointer brought over in gray code, so it may
	// keep reporting full a little after space frees but never misses full.
	assign wr_ready_out = (wgray_reg != {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]});
	assign rd_valid_out = (rgray_reg != wgray_s2_reg);
	assign wr_fire = wr_valid_in && wr_ready_out;
	assign rd_fire = rd_ready_in && rd_valid_out;
	assign wbin_next = wbin_reg + PTR_ONE;
	assign rbin_next = rbin_reg + PTR_ONE;
	assign rd_data_out = mem_reg[rbin_reg[AW-1:0]];

	// ----------------------------------------------------------------
	// Write domain
	// ----------------------------------------------------------------
	always_ff @(posedge wr_clk_in) begin
		if (wr_fire) begin
			mem_reg[wbin_reg[AW-1:0]] <= wr_data_in;
		end
	end

	always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
		if (!wr_rst_n_in) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			rgray_s1_reg <= '0;
			rgray_s2_reg <= '0;
		end else begin
			rgray_s1_reg <= rgray_reg;
			rgray_s2_reg <= rgray_s1_reg;
			if (wr_fire) begin
				wbin_reg <= wbin_next;
				wgray_reg <= wbin_next ^ (wbin_next >> 1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Read domain
	// ----------------------------------------------------------------
	always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
		if (!rd_rst_n_in) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			wgray_s1_reg <= '0;
			wgray_s2_reg <= '0;
		end else begin
			wgray_s1_reg <= wgray_reg;
			wgray_s2_reg <= wgray_s1_reg;
			if (rd_fire) begin
				rbin_reg <= rbin_next;
				rgray_reg <= rbin_next ^ (rbin_next >> 1);
			end
		end
	end

endmodule

// >>> erpi_top_assertions.sv
`timescale 1ns/100ps
// ----------
// Pin and stream checks
// ----------
module erpi_top_assertions (
	// Clock, reset and mode
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic mode_rmii_out,
	// Streams
	input wire logic tx_valid_in,
	input wire erpi_pkg::erpi_tx_byte_t tx_byte_in,
	input wire logic tx_ready_out,
	input wire logic tx_active_out,
	input wire logic rx_valid_out,
	input wire erpi_pkg::erpi_rx_word_t rx_word_out,
	input wire logic rx_ready_in,
	// Transmit pins
	input wire logic mii_transmit_clock_out,
	input wire logic mii_transmit_control_out,
	input wire logic mii_transmit_bit0_out,
	input wire logic mii_transmit_bit1_out,
	input wire logic mii_transmit_bit2_out,
	input wire logic mii_transmit_bit3_out
);
	import erpi_pkg::*;
	logic [3:0] txd;
	logic txc;
	logic ctl;
	assign txd = {mii_transmit_bit3_out, mii_transmit_bit2_out,
		mii_transmit_bit1_out, mii_transmit_bit0_out};
	assign txc = mii_transmit_clock_out;
	assign ctl = mii_transmit_control_out;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence rg_take;
		tx_valid_in && tx_ready_out && !mode_rmii_out;
	endsequence
	sequence rm_take;
		tx_valid_in && tx_ready_out && mode_rmii_out;
	endsequence
	// The PHY times transmit from this clock, and receive too in RMII, so a stuck phase stalls the link.
	AST_TXC_HIGH: assert property (txc |=> !txc)
		else $error("transmit clock high too long");
	AST_TXC_LOW: assert property ($fell(txc) |=> txc)
		else $error("transmit clock low too long");
	AST_RG_CTL: assert property (rg_take |=> txc && ctl ##1 ctl == !$past(tx_byte_in.err, 2))
		else $error("transmit control wrong");
	AST_RG_DATA: assert property (rg_take |=> txd == $past(tx_byte_in.data[3:0])
		##1 txd == $past(tx_byte_in.data[7:4], 2)) else $error("transmit nibble wrong");
	AST_RM_DATA: assert property (rm_take |=> !txc && txd[1:0] == $past(tx_byte_in.data[1:0])
		##2 txd[1:0] == $past(tx_byte_in.data[3:2], 3)
		##2 txd[1:0] == $past(tx_byte_in.data[5:4], 5)
		##2 txd[1:0] == $past(tx_byte_in.data[7:6], 7)) else $error("transmit dibit wrong");
	AST_RM_EN: assert property (rm_take |=> ctl [*8])
		else $error("transmit enable dropped");
	AST_RM_ACTIVE: assert property (mode_rmii_out && tx_ready_out && !tx_valid_in
		|=> !tx_active_out) else $error("enable without a byte");
	AST_RM_UNUSED: assert property (mode_rmii_out |-> txd[3:2] == 2'h0)
		else $error("unused lines driven");
	AST_RM_HOLD: assert property (mode_rmii_out && $past(mode_rmii_out) && !$fell(txc)
		|-> $stable({ctl, txd[1:0]})) else $error("dibit changed off clock fall");
	AST_MODE_IDLE: assert property ($changed(mode_rmii_out)
		|-> !$past(tx_active_out) && !$past(rx_valid_out)) else $error("mode changed busy");
	AST_RDY_PULSE: assert property (tx_ready_out |=> !tx_ready_out)
		else $error("ready longer than one cycle");
	AST_RX_HOLD: assert property (rx_valid_out && !rx_ready_in
		|=> rx_valid_out && $stable(rx_word_out)) else $error("receive word not held");
endmodule

bind erpi_top erpi_top_assertions chk (.sys_clk_in, .rst_n_in, .mode_rmii_out, .tx_valid_in,
	.tx_byte_in, .tx_ready_out, .tx_active_out, .rx_valid_out, .rx_word_out, .rx_ready_in,
	.mii_transmit_clock_out, .mii_transmit_control_out, .mii_transmit_bit0_out,
	.mii_transmit_bit1_out, .mii_transmit_bit2_out, .mii_transmit_bit3_out);

// >>> erpi_phy_model.sv
`timescale 1ns/100ps
module erpi_phy_model (
	// Clock and mode
	input wire logic sys_clk_in,
	input wire logic mode_rmii_in,
	// Transmit pins
	input wire logic tx_clk_in,
	input wire logic tx_ctl_in,
	input wire logic [3:0] txd_in,
	// Receive pins
	output logic rx_clk_out,
	output logic rx_ctl_out,
	output logic [3:0] rxd_out
);
	import erpi_pkg::*;
	erpi_tx_byte_t txq[$];
	logic [8:0] rq[$];
	logic [3:0] lo;
	logic [7:0] sh;
	logic en;
	logic bad;
	int n;
	// ----------
	// Receive clock edges after reset so the receive side leaves reset
	// ----------
	initial begin
		{rx_ctl_out, rxd_out, lo, sh, en, bad} = '0;
		n = 0;
		rx_clk_out = 1'b0;
		#800 repeat (4) #32 rx_clk_out = ~rx_clk_out;
	end
	// ----------
	// Transmit capture, mid-cycle where the pins are settled
	// ----------
	always @(negedge sys_clk_in) begin
		if (mode_rmii_in && tx_clk_in && tx_ctl_in) begin
			bad = bad | (|txd_in[3:2]);
			sh = {txd_in[1:0], sh[7:2]};
			n = n + 1;
			if (n == 4) begin
				txq.push_back({1'b0, sh});
				n = 0;
			end
		end else if (!mode_rmii_in && tx_clk_in) begin
			lo = txd_in;
			en = tx_ctl_in;
		end else if (!mode_rmii_in && en) begin
			txq.push_back({~tx_ctl_in, txd_in, lo});
			en = 1'b0;
		end
	end
	// ----------
	// Receive senders
	// ----------
	// The clock stands still between frames; undriven data shows the inverse of its last value.
	task automatic send_rg();
		logic v;
		logic [8:0] w;
		w = '0;
		for (int i = 0; i < rq.size() + 4; i++) begin
			v = i < rq.size();
			w = v ? rq[i] : ~w;
			{rx_ctl_out, rxd_out} = {v, w[3:0]};
			#16 rx_clk_out = 1'b1;
			#16 {rx_ctl_out, rxd_out} = {v & ~w[8], w[7:4]};
			#16 rx_clk_out = 1'b0;
			#16;
		end
	endtask
	task automatic send_rm();
		for (int i = 0; i < 4 * rq.size() + 8; i++) begin
			@(negedge tx_clk_in);
			rx_ctl_out = i < 4 * rq.size();
			rxd_out[1:0] = rx_ctl_out ? rq[i / 4][2 * (i % 4) +: 2] : ~rxd_out[1:0];
			rxd_out[3:2] = ~rxd_out[3:2];
		end
	endtask
endmodule

// >>> test_erpi_top.sv
`timescale 1ns/100ps
module test_erpi_top;
	import erpi_pkg::*;
	logic sys_clk_in;
	logic rst_n_in;
	logic mode_rmii_in;
	logic mode_rmii_out;
	logic tx_valid_in;
	erpi_tx_byte_t tx_byte_in;
	logic tx_ready_out;
	logic tx_active_out;
	logic rx_valid_out;
	erpi_rx_word_t rx_word_out;
	logic rx_ready_in;
	logic rx_carrier_out;
	logic rx_overflow_out;
	logic rx_overflow_clear_in;
	logic mii_transmit_clock_out;
	logic mii_transmit_control_out;
	logic [3:0] txd;
	logic mii_receive_clock_in;
	logic mii_receive_control_in;
	logic [3:0] rxd;
	int err_count;
	int checked;
	logic [8:0] fr[4] = '{9'h055, 9'h0D5, 9'h1A3, 9'h03C};
	erpi_top uut (
		.sys_clk_in, .rst_n_in, .mode_rmii_in, .mode_rmii_out, .tx_valid_in, .tx_byte_in,
		.tx_ready_out, .tx_active_out, .rx_valid_out, .rx_word_out, .rx_ready_in,
		.rx_carrier_out, .rx_overflow_out, .rx_overflow_clear_in, .mii_transmit_clock_out,
		.mii_transmit_control_out, .mii_transmit_bit0_out(txd[0]),
		.mii_transmit_bit1_out(txd[1]), .mii_transmit_bit2_out(txd[2]),
		.mii_transmit_bit3_out(txd[3]), .mii_receive_clock_in, .mii_receive_control_in,
		.mii_receive_bit0_in(rxd[0]), .mii_receive_bit1_in(rxd[1]),
		.mii_receive_bit2_in(rxd[2]), .mii_receive_bit3_in(rxd[3])
	);
	erpi_phy_model phy (
		.sys_clk_in, .mode_rmii_in(mode_rmii_out), .tx_clk_in(mii_transmit_clock_out),
		.tx_ctl_in(mii_transmit_control_out), .txd_in(txd), .rx_clk_out(mii_receive_clock_in),
		.rx_ctl_out(mii_receive_control_in), .rxd_out(rxd)
	);
	// ----------
	// Shared tasks
	// ----------
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic hang();
		err_count++;
		$display("Error at %0t: wait ran out, got %0h, expected %0h", $time, 1'h0, 1'h1);
		results();
	endtask
	task automatic rx_collect(input logic m, output int got, output logic car);
		got = 0;
		car = 1'b0;
		for (int k = 0; k < 300 && got < phy.rq.size(); k++) begin
			@(negedge sys_clk_in);
			rx_ready_in = 1'b1;
			car = car | rx_carrier_out;
			if (rx_valid_out === 1'b1) begin
				cmp(rx_word_out, {got == 0, m ? 1'b0 : phy.rq[got][8], phy.rq[got][7:0]});
				got++;
			end
		end
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_reset();
		repeat (6) @(posedge sys_clk_in);
		cmp({mode_rmii_out, tx_ready_out, tx_active_out, rx_valid_out, rx_overflow_out,
			mii_transmit_clock_out, mii_transmit_control_out, txd[2:0]}, 10'h000);
		@(negedge sys_clk_in);
		rst_n_in = 1'b1;
		$display("reset done");
	endtask
	task automatic tx_frame();
		logic m;
		m = mode_rmii_out;
		phy.txq.delete();
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk_in);
			tx_valid_in = 1'b1;
			tx_byte_in = fr[i];
			for (int k = 0; k < 20 && tx_ready_out !== 1'b1; k++) @(negedge sys_clk_in);
			if (tx_ready_out !== 1'b1) hang();
		end
		@(negedge sys_clk_in);
		tx_valid_in = 1'b0;
		for (int k = 0; k < 50 && phy.txq.size() < 4; k++) @(negedge sys_clk_in);
		if (phy.txq.size() < 4) hang();
		for (int i = 0; i < 4; i++) cmp({1'b0, phy.txq[i]}, {1'b0, m ? 1'b0 : fr[i][8], fr[i][7:0]});
		cmp({9'h0, phy.bad}, 10'h0);
		$display("transmit frame done, mode %0d", m);
	endtask
	task automatic rx_frame(input logic m);
		int got;
		logic car;
		phy.rq = {fr[0], fr[1], fr[2], fr[3]};
		fork
			if (m) phy.send_rm(); else phy.send_rg();
		join_none
		rx_collect(m, got, car);
		wait fork;
		cmp(10'(got), 10'h004);
		cmp({9'h0, car}, 10'h001);
		$display("receive frame done, mode %0d", m);
	endtask
	task automatic t_overflow();
		int got;
		logic car;
		@(negedge sys_clk_in);
		rx_ready_in = 1'b0;
		phy.rq.delete();
		for (int i = 0; i < 40; i++) phy.rq.push_back(9'(i));
		phy.send_rg();
		cmp({9'h0, rx_overflow_out}, 10'h001);
		rx_collect(1'b0, got, car);
		cmp({9'h0, got >= 32 && got <= 34}, 10'h001);
		@(negedge sys_clk_in);
		rx_overflow_clear_in = 1'b1;
		@(negedge sys_clk_in);
		rx_overflow_clear_in = 1'b0;
		cmp({9'h0, rx_overflow_out}, 10'h000);
		$display("overflow done");
	endtask
	task automatic t_mode();
		fork
			tx_frame();
			begin
				for (int k = 0; k < 20 && tx_active_out !== 1'b1; k++) @(negedge sys_clk_in);
				mode_rmii_in = 1'b1;
				@(negedge sys_clk_in);
				cmp({9'h0, mode_rmii_out}, 10'h000);
			end
		join
		for (int k = 0; k < 50 && mode_rmii_out !== 1'b1; k++) @(negedge sys_clk_in);
		cmp({9'h0, mode_rmii_out}, 10'h001);
		$display("mode change done");
	endtask
	// ----------
	// Main sequence
	// ----------
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#2000000;
		hang();
	end
	initial begin
		{rst_n_in, mode_rmii_in, tx_valid_in, tx_byte_in, rx_ready_in, rx_overflow_clear_in} = '0;
		err_count = 0;
		checked = 0;
		t_reset();
		tx_frame();
		rx_frame(1'b0);
		t_overflow();
		t_mode();
		tx_frame();
		rx_frame(1'b1);
		results();
	end
endmodule
